// ===== rtl/nlcs_pkg.sv
// package of constants shared by the no-load / sum-sign device and its host
package nlcs_pkg;
  // register addresses on the device register port (8-bit index)
  localparam logic [7:0] ADDR_IRQ_STATUS_0 = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS_1 = 8'h01;
  localparam logic [7:0] ADDR_IRQ_MASK_0   = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK_1   = 8'h03;
  localparam logic [7:0] ADDR_POWER_SIGN   = 8'h04;
  localparam logic [7:0] ADDR_NOLOAD_PHASE = 8'h05;
  localparam logic [7:0] ADDR_ACT_THR      = 8'h06;
  localparam logic [7:0] ADDR_REACT_THR    = 8'h07;
  localparam logic [7:0] ADDR_APP_THR      = 8'h08;
  // status 0 sum reversal flag positions, paths 1..3
  localparam int BIT_REV_P1 = 9;
  localparam int BIT_REV_P2 = 13;
  localparam int BIT_REV_P3 = 18;
  // power sign register sum sign positions, paths 1..3
  localparam int BIT_SIGN_P1 = 3;
  localparam int BIT_SIGN_P2 = 7;
  localparam int BIT_SIGN_P3 = 8;
  // status 1 no-load flag positions
  localparam int BIT_NL_TOT  = 0;
  localparam int BIT_NL_FUND = 1;
  localparam int BIT_NL_APP  = 2;
  // no-load phase register fields (low bit of each 3-bit group)
  localparam int NLP_TOT_LSB  = 0;
  localparam int NLP_FUND_LSB = 3;
  localparam int NLP_APP_LSB  = 6;
  localparam int NLP_W        = 9;
  localparam int THR_W        = 24;
  localparam int DSP_W        = 28;
  localparam int NPH          = 3;
  localparam int NPATH        = 3;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [23:0] THR_RESET  = 24'h00_0000;
  // active-only variant value for the reactive threshold
  localparam logic [23:0] THR_ACTIVE_ONLY = 24'h80_0000;
  localparam logic [27:0] FULL_SCALE_POWER = 28'h1FF_6A6B;
endpackage

// ===== rtl/nlcs_if.sv
// register port between host and device, with the two interrupt pins
`timescale 1ns/1ps
interface nlcs_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        int0_n;
  logic        int1_n;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata,
                output int0_n, output int1_n);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
                input int0_n, input int1_n);
endinterface

// ===== rtl/nlcs_device.sv
// no-load detectors and pulse-path sum sign detector with status, mask and interrupt pins
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - check sum sign at each stage-one threshold
// - sign change sets reversal flag bits 18/13/9
// - flag set at next pulse falling edge
// - sign bits 8/7/3 update with flag
// - masked reversal flag drives pin 0 low
// - host reads sign; write-one clears flag
// - total no-load blocks total energy accumulation
// - negative active/reactive threshold disables detectors
// - thresholds read top nibble zero, sign-extend 28; code zero-fills bits 31:24
// - active-only variant: reactive threshold 0x800000
// - total flag bit0 with phase bits 2:0
// - total flag on entry/exit, mask bit0
// - fundamental no-load blocks fundamental energies
// - fundamental flag bit1, bits 5:3, irq_mask_1
// - apparent no-load, negative threshold disables
// - apparent flag bit2, bits 8:6, mask2
// - host reads phase register, write-one clears
// - software computes thresholds from full-scale power
// - flags set regardless of mask
// - pin low until all masked flags cleared
// - masks cleared at reset
module nlcs_device (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  nlcs_if.dev                             bus,
  input  wire logic                       power_update_in,
  input  wire logic signed [27:0]         tot_act_in    [nlcs_pkg::NPH],
  input  wire logic signed [27:0]         tot_react_in  [nlcs_pkg::NPH],
  input  wire logic signed [27:0]         fund_act_in   [nlcs_pkg::NPH],
  input  wire logic signed [27:0]         fund_react_in [nlcs_pkg::NPH],
  input  wire logic signed [27:0]         app_in        [nlcs_pkg::NPH],
  input  wire logic [nlcs_pkg::NPATH-1:0] thr_reached_in,
  input  wire logic [nlcs_pkg::NPATH-1:0] sum_negative_in,
  input  wire logic [nlcs_pkg::NPATH-1:0] pulse_output_in,
  output logic [nlcs_pkg::NPH-1:0]        tot_acc_en_out,
  output logic [nlcs_pkg::NPH-1:0]        fund_acc_en_out,
  output logic [nlcs_pkg::NPH-1:0]        app_acc_en_out
);
  import nlcs_pkg::*;

  typedef struct packed {
    logic [31:0]       st0;
    logic [31:0]       st1;
    logic [31:0]       irq_mask_0;
    logic [31:0]       irq_mask_1;
    logic [NPATH-1:0]  sign;      // sign taken at last threshold
    logic [NPATH-1:0]  pend;      // change waiting for pulse edge
    logic [NPATH-1:0]  sign_rep;  // sign shown in power sign register
    logic [NPATH-1:0]  pulse_q;
    logic [NLP_W-1:0]  nlp;
    logic [THR_W-1:0]  act_thr;
    logic [THR_W-1:0]  react_thr;
    logic [THR_W-1:0]  app_thr;
    logic [31:0]       rdata;
    logic              int0_n;
    logic              int1_n;
    logic [NPH-1:0]    tot_en;
    logic [NPH-1:0]    fund_en;
    logic [NPH-1:0]    app_en;
  } nlcs_dev_state_t;

  nlcs_dev_state_t s_q;
  nlcs_dev_state_t s_d;

  localparam int REV_POS  [NPATH] = '{BIT_REV_P1, BIT_REV_P2, BIT_REV_P3};
  localparam int SIGN_POS [NPATH] = '{BIT_SIGN_P1, BIT_SIGN_P2, BIT_SIGN_P3};

  // used for every no-load detector and every phase
  function automatic logic at_or_below(input logic signed [27:0] p,
                                       input logic [THR_W-1:0]   thr);
    logic signed [DSP_W:0] mag;
    logic signed [DSP_W:0] lim;
    mag = (p < 0) ? -{p[27], p} : {p[27], p};
    lim = {{(DSP_W+1-THR_W){thr[THR_W-1]}}, thr};
    at_or_below = (mag <= lim);
  endfunction

  function automatic logic [31:0] thr_word(input logic [THR_W-1:0] thr);
    thr_word = {{(32-THR_W){1'b0}}, thr};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [NPH-1:0] nl_tot;
    logic [NPH-1:0] nl_fund;
    logic [NPH-1:0] nl_app;
    logic [31:0]    sign_word;
    logic [31:0]    phase_word;
    logic           ev_nl;
    logic           ev_fnl;
    logic           ev_anl;
    logic           clr0;
    logic           clr1;
    nl_tot   = '0;
    nl_fund  = '0;
    nl_app   = '0;
    ev_nl      = 1'b0;
    ev_fnl     = 1'b0;
    ev_anl     = 1'b0;
    sign_word  = WORD_ZERO;
    phase_word = {{(32-NLP_W){1'b0}}, s_q.nlp};
    s_d      = s_q;
    s_d.pulse_q = pulse_output_in;
    clr0 = bus.wr && (bus.addr == ADDR_IRQ_STATUS_0);
    clr1 = bus.wr && (bus.addr == ADDR_IRQ_STATUS_1);
    // write-one clear first; later sets override it so no event is lost
    if (clr0) begin
      s_d.st0 = s_q.st0 & ~bus.wdata;
    end
    if (clr1) begin
      s_d.st1 = s_q.st1 & ~bus.wdata;
    end
    for (int k = 0; k < NPATH; k++) begin
      if (thr_reached_in[k]) begin
        s_d.sign[k] = sum_negative_in[k];
        if (sum_negative_in[k] != s_q.sign[k]) begin
          s_d.pend[k] = 1'b1;
        end
      end
      if ((s_q.pend[k] || s_d.pend[k]) && s_q.pulse_q[k] && !pulse_output_in[k]) begin
        s_d.pend[k]        = 1'b0;
        s_d.st0[REV_POS[k]] = 1'b1;
        s_d.sign_rep[k]    = s_d.sign[k];
      end
    end
    for (int p = 0; p < NPH; p++) begin
      nl_tot[p]  = !s_q.act_thr[THR_W-1] && !s_q.react_thr[THR_W-1] &&
                   at_or_below(tot_act_in[p], s_q.act_thr) &&
                   at_or_below(tot_react_in[p], s_q.react_thr);
      nl_fund[p] = !s_q.act_thr[THR_W-1] && !s_q.react_thr[THR_W-1] &&
                   at_or_below(fund_act_in[p], s_q.act_thr) &&
                   at_or_below(fund_react_in[p], s_q.react_thr);
      nl_app[p]  = !s_q.app_thr[THR_W-1] &&
                   at_or_below(app_in[p], s_q.app_thr);
    end
    ev_nl  = power_update_in && (nl_tot  != s_q.nlp[NLP_TOT_LSB +: NPH]);
    ev_fnl = power_update_in && (nl_fund != s_q.nlp[NLP_FUND_LSB +: NPH]);
    ev_anl = power_update_in && (nl_app  != s_q.nlp[NLP_APP_LSB +: NPH]);
    if (ev_nl) begin
      s_d.st1[BIT_NL_TOT] = 1'b1;
      s_d.nlp[NLP_TOT_LSB +: NPH] = nl_tot;
    end
    if (ev_fnl) begin
      s_d.st1[BIT_NL_FUND] = 1'b1;
      s_d.nlp[NLP_FUND_LSB +: NPH] = nl_fund;
    end
    if (ev_anl) begin
      s_d.st1[BIT_NL_APP] = 1'b1;
      s_d.nlp[NLP_APP_LSB +: NPH] = nl_app;
    end
    if (power_update_in) begin
      s_d.tot_en  = ~nl_tot;
      s_d.fund_en = ~nl_fund;
      s_d.app_en  = ~nl_app;
    end
    if (bus.wr) begin
      case (bus.addr)
        ADDR_IRQ_MASK_0: s_d.irq_mask_0     = bus.wdata;
        ADDR_IRQ_MASK_1: s_d.irq_mask_1     = bus.wdata;
        ADDR_ACT_THR:    s_d.act_thr   = bus.wdata[THR_W-1:0];
        ADDR_REACT_THR:  s_d.react_thr = bus.wdata[THR_W-1:0];
        ADDR_APP_THR:    s_d.app_thr   = bus.wdata[THR_W-1:0];
        default:         s_d.irq_mask_0     = s_d.irq_mask_0;
      endcase
    end
    for (int k = 0; k < NPATH; k++) begin
      sign_word[SIGN_POS[k]] = s_q.sign_rep[k];
    end
    s_d.rdata = WORD_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_IRQ_STATUS_0: s_d.rdata = s_q.st0;
        ADDR_IRQ_STATUS_1: s_d.rdata = s_q.st1;
        ADDR_IRQ_MASK_0:   s_d.rdata = s_q.irq_mask_0;
        ADDR_IRQ_MASK_1:   s_d.rdata = s_q.irq_mask_1;
        ADDR_POWER_SIGN:   s_d.rdata = sign_word;
        ADDR_NOLOAD_PHASE: s_d.rdata = phase_word;
        ADDR_ACT_THR:      s_d.rdata = thr_word(s_q.act_thr);
        ADDR_REACT_THR:    s_d.rdata = thr_word(s_q.react_thr);
        ADDR_APP_THR:      s_d.rdata = thr_word(s_q.app_thr);
        default:           s_d.rdata = WORD_ZERO;
      endcase
    end
    // pins follow the next flag state so they fall with the flag
    s_d.int0_n = ~|(s_d.st0 & s_d.irq_mask_0);
    s_d.int1_n = ~|(s_d.st1 & s_d.irq_mask_1);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q           <= '0;
      s_q.int0_n    <= 1'b1;
      s_q.int1_n    <= 1'b1;
      s_q.pulse_q   <= '1;
      s_q.act_thr   <= THR_RESET;
      s_q.react_thr <= THR_RESET;
      s_q.app_thr   <= THR_RESET;
      s_q.tot_en    <= '1;
      s_q.fund_en   <= '1;
      s_q.app_en    <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rdata       = s_q.rdata;
  assign bus.int0_n      = s_q.int0_n;
  assign bus.int1_n      = s_q.int1_n;
  assign tot_acc_en_out  = s_q.tot_en;
  assign fund_acc_en_out = s_q.fund_en;
  assign app_acc_en_out  = s_q.app_en;
endmodule

// ===== rtl/nlcs_host.sv
// host end: services the interrupt pins, reads status then companion register, clears
`timescale 1ns/1ps
module nlcs_host (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  nlcs_if.host             bus,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [31:0] cfg_data_in,
  output logic             busy_out,
  output logic [31:0]      last_status_out,
  output logic [31:0]      last_detail_out,
  output logic             event_out
);
  import nlcs_pkg::*;

  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_RDST  = 6'b000010,
    H_WTST  = 6'b000100,
    H_RDDET = 6'b001000,
    H_WTDET = 6'b010000,
    H_CLR   = 6'b100000
  } nlcs_hstate_t;

  typedef struct packed {
    nlcs_hstate_t st;
    logic         which;  // 0: status 0 / sign, 1: status 1 / phase
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  status;
    logic [31:0]  detail;
    logic         event_p;
    logic         busy;
  } nlcs_host_state_t;

  nlcs_host_state_t h_q;
  nlcs_host_state_t h_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    h_d = h_q;
    h_d.wr = 1'b0;
    h_d.rd = 1'b0;
    h_d.event_p = 1'b0;
    case (h_q.st)
      H_IDLE: begin
        if (cfg_wr_in) begin
          h_d.wr    = 1'b1;
          h_d.addr  = cfg_addr_in;
          h_d.wdata = cfg_data_in;
        end else if (!bus.int0_n || !bus.int1_n) begin
          h_d.which = bus.int0_n;
          h_d.addr  = bus.int0_n ? ADDR_IRQ_STATUS_1 : ADDR_IRQ_STATUS_0;
          h_d.rd    = 1'b1;
          h_d.st    = H_RDST;
        end
      end
      H_RDST: h_d.st = H_WTST;
      H_WTST: begin
        h_d.status = bus.rdata;
        // companion register read right after status
        h_d.addr = h_q.which ? ADDR_NOLOAD_PHASE : ADDR_POWER_SIGN;
        h_d.rd   = 1'b1;
        h_d.st   = H_RDDET;
      end
      H_RDDET: h_d.st = H_WTDET;
      H_WTDET: begin
        h_d.detail = bus.rdata;
        h_d.addr   = h_q.which ? ADDR_IRQ_STATUS_1 : ADDR_IRQ_STATUS_0;
        h_d.wdata  = h_q.status;
        h_d.wr     = 1'b1;
        h_d.st     = H_CLR;
      end
      H_CLR: begin
        h_d.event_p = 1'b1;
        h_d.st      = H_IDLE;
      end
      default: h_d.st = H_IDLE;
    endcase
    // registered so the busy output comes straight from a flip-flop
    h_d.busy = (h_d.st != H_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      h_q    <= '0;
      h_q.st <= H_IDLE;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.addr        = h_q.addr;
  assign bus.wdata       = h_q.wdata;
  assign bus.wr          = h_q.wr;
  assign bus.rd          = h_q.rd;
  assign busy_out        = h_q.busy;
  assign last_status_out = h_q.status;
  assign last_detail_out = h_q.detail;
  assign event_out       = h_q.event_p;
endmodule

// ===== testbench/nlcs_sva.sv
// assertions on the register port and interrupt pins between host and device
`timescale 1ns/1ps
module nlcs_sva
  import nlcs_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        int0_n,
  input wire logic        int1_n
);
  localparam logic [31:0] ST0_M = 32'h0004_2200;
  localparam logic [31:0] SGN_M = 32'h0000_0188;
  logic [31:0] m0_q;
  logic [31:0] m1_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////
  // mask shadows, so a pin can be tied to the mask that allows it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      m0_q <= WORD_ZERO;
      m1_q <= WORD_ZERO;
    end else if (wr && addr == ADDR_IRQ_MASK_0) begin
      m0_q <= wdata;
    end else if (wr && addr == ADDR_IRQ_MASK_1) begin
      m1_q <= wdata;
    end
  end
  ////////////////////////////////////////
  sequence s_rd_st0;  rd && addr == ADDR_IRQ_STATUS_0;  endsequence
  sequence s_rd_sign; rd && addr == ADDR_POWER_SIGN;    endsequence
  sequence s_clr0;    wr && addr == ADDR_IRQ_STATUS_0;  endsequence
  sequence s_rd_st1;  rd && addr == ADDR_IRQ_STATUS_1;  endsequence
  sequence s_rd_nlp;  rd && addr == ADDR_NOLOAD_PHASE;  endsequence
  sequence s_clr1;    wr && addr == ADDR_IRQ_STATUS_1;  endsequence
  a_rdata_one_cycle: assert property (!rd |=> rdata == WORD_ZERO)
    else $error("read data outside its cycle");
  a_strobe_exclusive: assert property (!(wr && rd))
    else $error("write and read strobe together");
  a_pin0_masked: assert property (!int0_n |-> (m0_q & ST0_M) != WORD_ZERO)
    else $error("pin 0 low without mask");
  a_pin1_masked: assert property (!int1_n |-> m1_q[2:0] != 3'h0)
    else $error("pin 1 low without mask");
  a_pin0_release: assert property ($rose(int0_n) |-> $past(wr) &&
    ($past(addr) == ADDR_IRQ_STATUS_0 || $past(addr) == ADDR_IRQ_MASK_0))
    else $error("pin 0 rose without clear");
  a_pin1_release: assert property ($rose(int1_n) |-> $past(wr) &&
    ($past(addr) == ADDR_IRQ_STATUS_1 || $past(addr) == ADDR_IRQ_MASK_1))
    else $error("pin 1 rose without clear");
  a_st0_fields: assert property (s_rd_st0 |=> (rdata & ~ST0_M) == WORD_ZERO)
    else $error("status 0 stray bits");
  a_sign_fields: assert property (s_rd_sign |=> (rdata & ~SGN_M) == WORD_ZERO)
    else $error("sign register stray bits");
  a_nlp_fields: assert property (s_rd_nlp |=> rdata[31:9] == 23'h0)
    else $error("phase register stray bits");
  a_sign_after_st0: assert property (s_rd_st0 |-> ##2 s_rd_sign ##2 s_clr0)
    else $error("status 0 service order");
  a_nlp_after_st1: assert property (s_rd_st1 |-> ##2 s_rd_nlp ##2 s_clr1)
    else $error("status 1 service order");
endmodule

// ===== testbench/testbench.sv
// testbench: host and device joined, user sides driven and judged
`timescale 1ns/1ps
module testbench;
  import nlcs_pkg::*;
  logic               clk_in, resetn_in, power_update_in, cfg_wr_in;
  logic [7:0]         cfg_addr_in;
  logic [31:0]        cfg_data_in, last_status_out, last_detail_out;
  logic               busy_out, event_out;
  logic [2:0]         thr_reached_in, sum_negative_in, pulse_output_in;
  logic [2:0]         tot_acc_en_out, fund_acc_en_out, app_acc_en_out;
  logic signed [27:0] ta [NPH], tr [NPH], fa [NPH], fr [NPH], aa [NPH];
  int                 n_errors, n_compared;
  nlcs_if bus_if ();
  nlcs_device i_nlcs_device (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if),
    .power_update_in(power_update_in), .tot_act_in(ta), .tot_react_in(tr),
    .fund_act_in(fa), .fund_react_in(fr), .app_in(aa), .thr_reached_in(thr_reached_in),
    .sum_negative_in(sum_negative_in), .pulse_output_in(pulse_output_in),
    .tot_acc_en_out(tot_acc_en_out), .fund_acc_en_out(fund_acc_en_out),
    .app_acc_en_out(app_acc_en_out));
  nlcs_host i_nlcs_host (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if),
    .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in), .cfg_data_in(cfg_data_in),
    .busy_out(busy_out), .last_status_out(last_status_out),
    .last_detail_out(last_detail_out), .event_out(event_out));
  nlcs_sva i_nlcs_sva (.clk_in(clk_in), .resetn_in(resetn_in), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .int0_n(bus_if.int0_n), .int1_n(bus_if.int1_n));
  ////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host takes a request only while idle
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    while (busy_out !== 1'b0) @(posedge clk_in);
    cfg_wr_in   <= 1'b1;
    cfg_addr_in <= a;
    cfg_data_in <= d;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic upd;
    @(posedge clk_in);
    power_update_in <= 1'b1;
    @(posedge clk_in);
    power_update_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // bounded wait for the host to finish one service
  task automatic svc(input logic [31:0] st, input logic [31:0] dt);
    int i;
    i = 0;
    do begin
      @(posedge clk_in);
      #1;
      i++;
    end while (event_out !== 1'b1 && i < 60);
    chk(32'(event_out), 32'h1);
    chk(last_status_out, st);
    chk(last_detail_out, dt);
  endtask
  task automatic quiet;
    repeat (10) @(posedge clk_in);
    chk(32'({bus_if.int0_n, bus_if.int1_n}), 32'h3);
  endtask
  // arm, then prove nothing shows before the pulse falls
  task automatic sgn(input logic [2:0] p, input logic [2:0] n);
    @(posedge clk_in);
    thr_reached_in  <= p;
    sum_negative_in <= n;
    @(posedge clk_in);
    thr_reached_in <= 3'b000;
    repeat (5) @(posedge clk_in);
    chk(32'(bus_if.int0_n), 32'h1);
    pulse_output_in <= ~p;
    @(posedge clk_in);
    pulse_output_in <= 3'b111;
  endtask
  ////////////////////////////////////////
  task automatic t_sign;
    logic [31:0] st [3];
    logic [31:0] sg [3];
    st = '{32'h0000_0200, 32'h0000_2000, 32'h0004_0000};
    sg = '{32'h0000_0008, 32'h0000_0088, 32'h0000_0188};
    cfg(ADDR_IRQ_MASK_0, 32'h0004_2200);
    for (int k = 0; k < 3; k++) begin
      sgn(3'(1 << k), 3'b111);
      svc(st[k], sg[k]);
    end
    sgn(3'b111, 3'b000);
    svc(32'h0004_2200, 32'h0);
    sgn(3'b001, 3'b000);
    quiet();
  endtask
  task automatic t_total;
    cfg(ADDR_APP_THR, 32'h0080_0000);
    cfg(ADDR_ACT_THR, 32'h0000_0100);
    cfg(ADDR_REACT_THR, 32'h0000_0100);
    ta[0] <= 28'sh000_0100;
    tr[0] <= -28'sh000_0100;
    ta[1] <= 28'sh000_0101;
    tr[1] <= 28'sh000_0000;
    upd();
    quiet();
    chk(32'(tot_acc_en_out), 32'h6);
    cfg(ADDR_IRQ_MASK_1, 32'h0000_0007);
    svc(32'h1, 32'h1);
    upd();
    quiet();
    ta[0] <= 28'sh000_0101;
    upd();
    svc(32'h1, 32'h0);
    chk(32'(tot_acc_en_out), 32'h7);
    fa[2] <= -28'sh000_0080;
    fr[2] <= 28'sh000_0080;
    upd();
    svc(32'h2, 32'h20);
    chk(32'(fund_acc_en_out), 32'h3);
  endtask
  task automatic t_app;
    cfg(ADDR_APP_THR, 32'(FULL_SCALE_POWER >> 16));
    aa[1] <= 28'sh000_01FF;
    upd();
    svc(32'h4, 32'h0A0);
    chk(32'(app_acc_en_out), 32'h5);
    cfg(ADDR_APP_THR, 32'h00FF_FFFF);
    upd();
    svc(32'h4, 32'h20);
    ta[0] <= 28'sh000_0000;
    cfg(ADDR_ACT_THR, 32'h0080_0000);
    cfg(ADDR_REACT_THR, 32'(THR_ACTIVE_ONLY));
    upd();
    svc(32'h2, 32'h0);
    chk(32'({app_acc_en_out, fund_acc_en_out, tot_acc_en_out}), 32'h1FF);
  endtask
  ////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
  initial begin
    n_errors = 0;
    n_compared = 0;
    resetn_in = 1'b0;
    power_update_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_addr_in = 8'h00;
    cfg_data_in = 32'h0;
    thr_reached_in = 3'b000;
    sum_negative_in = 3'b000;
    pulse_output_in = 3'b111;
    for (int i = 0; i < NPH; i++) begin
      ta[i] = 28'sh010_0000;
      tr[i] = 28'sh010_0000;
      fa[i] = 28'sh010_0000;
      fr[i] = 28'sh010_0000;
      aa[i] = 28'sh010_0000;
    end
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk(32'({bus_if.int0_n, bus_if.int1_n}), 32'h3);
    chk(32'({app_acc_en_out, fund_acc_en_out, tot_acc_en_out}), 32'h1FF);
    t_sign();
    t_total();
    t_app();
    complete_run();
  end
endmodule
